//--- common/rbtr_pkg.sv
/*
  Shared constants and types of the real-time bus trace recorder: register map,
  control field positions, range, filter and qualification modes, the sampled
  bus cycle and the stored trace entry.
  Assumes a 50 MHz system clock and 32-bit AHB-Lite register access.
*/
`default_nettype none
package rbtr_pkg;
  localparam int unsigned TRACE_DEPTH   = 262144;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TS_RES_NS     = 1000;
  localparam int unsigned US_CYCLES     = (TS_RES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0]  US_DIV_LAST   = 6'(US_CYCLES - 1);

  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_WRPTR     = 8'h08;
  localparam logic [7:0] OFS_TP_ADDR   = 8'h0c;
  localparam logic [7:0] OFS_START_ADR = 8'h10;
  localparam logic [7:0] OFS_END_ADR   = 8'h14;
  localparam logic [7:0] OFS_RD_INDEX  = 8'h18;
  localparam logic [7:0] OFS_RD_WORD0  = 8'h1c;
  localparam logic [7:0] OFS_RD_WORD1  = 8'h20;
  localparam logic [7:0] OFS_RD_WORD2  = 8'h24;
  localparam logic [7:0] OFS_RD_WORD3  = 8'h28;

  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_FILT_LSB  = 3;
  localparam int unsigned CTRL_QUAL_LSB  = 5;
  localparam int unsigned CTRL_START_TRG = 7;
  localparam int unsigned CTRL_ARM       = 8;
  localparam int unsigned CTRL_SUSPEND   = 9;
  localparam int unsigned CTRL_TP_TRG    = 10;
  localparam int unsigned CTRL_END_TRG   = 11;
  localparam logic [11:0] CTRL_RST       = 12'h000;
  localparam logic [11:0] CTRL_WR_MASK   = 12'heff;

  localparam int unsigned PRB_BREAK_BIT = 7;
  localparam int unsigned PRB_TRACE_BIT = 6;
  localparam logic [3:0]  QFILL_MAX     = 4'h8;
  localparam logic        BUS_WIDTH_16  = 1'b1;

  typedef enum logic [2:0] {RANGE_BREAK, RANGE_BEFORE, RANGE_ABOUT, RANGE_AFTER, RANGE_FULL} rbtr_range_type;
  typedef enum logic [1:0] {FILT_TOTAL, FILT_SELECT, FILT_EXCLUDE} rbtr_filt_type;
  typedef enum logic [1:0] {QUAL_SINGLE, QUAL_LEVEL, QUAL_WINDOW} rbtr_qual_type;
  typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_WAIT, ST_POST, ST_DONE} rbtr_state_type;
  typedef enum logic [3:0] {
    BIU_NO_CHANGE, BIU_WAIT, BIU_BYTE_READ_ML_ON, BIU_FETCH, BIU_DISCONTINUOUS_FETCH,
    BIU_WORD_READ_ML_ON, BIU_INT_ACK, BIU_BYTE_READ, BIU_BYTE_WRITE, BIU_DMA_BYTE_READ,
    BIU_DMA_BYTE_WRITE, BIU_WORD_READ, BIU_WORD_WRITE, BIU_DMA_WORD_READ, BIU_DMA_WORD_WRITE
  } rbtr_biu_type;

  typedef struct packed {
    logic [23:0]  addr;
    logic [15:0]  data;
    logic         upper_byte_enable_n;
    rbtr_biu_type bus_interface_unit;
    logic [1:0]   rw;
    logic [2:0]   opcode_size;
    logic [2:0]   operand_size;
    logic [3:0]   queue_fill;
    logic         bus_cycle_valid_n;
  } rbtr_bus_type;

  typedef struct packed {
    rbtr_bus_type bus;
    logic         bus_width_16;
    logic [7:0]   probes;
    logic [31:0]  timestamp;
  } rbtr_entry_type;

  localparam int unsigned ENTRY_W = $bits(rbtr_entry_type);
endpackage
`default_nettype wire

//--- design/rbtr_recorder.sv
/*
  Real-time bus trace recorder with an AHB-Lite register slave.
  Assumes target bus, probe and run pins are asynchronous and are resynchronised
  here; the trace memory lives in rbtr_trace_ram.
*/
`default_nettype none
// Overview of operation
// - Stop range keeps newest DEPTH cycles, frozen once the program halts.
// - Before range keeps DEPTH cycles preceding the trace point, then stops.
// - About range keeps half before and half after the trace point.
// - After range starts at the trace point and stops after DEPTH writes.
// - Full range stores the first DEPTH cycles after arming.
// - Total filter writes every sampled cycle.
// - Select filter writes only cycles where qualification is true.
// - Exclude filter writes only cycles where qualification is false.
// - Single qualification marks only the cycle the start event appears.
// - Level qualification holds while the start event is present.
// - Window qualification runs from start event through end event cycle.
// - Address, data and status count only while cycle-valid is low.
// - Each entry stores the upper-byte enable level.
// - Each entry stores instruction-queue fill, 0 to 8 bytes.
// - Each entry stores the bus width, always 16 bits.
// - Break-trigger probe is sampled, stored and offered as break event.
// - Trace-trigger probe is sampled, stored and offered as trace event.
// - Each entry stores all eight probe inputs, bits 7 to 0.
// - Each entry stores microseconds elapsed since program start.
// - Host may suspend recording; writes stop until resumed.
module rbtr_recorder #(
  parameter int unsigned DEPTH = rbtr_pkg::TRACE_DEPTH
) (
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  clk_en_in,
  input  wire logic                  hsel_in,
  input  wire logic [31:0]           haddr_in,
  input  wire logic [1:0]            htrans_in,
  input  wire logic                  hwrite_in,
  input  wire logic [2:0]            hsize_in,
  input  wire logic [31:0]           hwdata_in,
  input  wire logic                  hready_in,
  output logic      [31:0]           hrdata_out,
  output logic                       hreadyout_out,
  output logic                       hresp_out,
  input  wire rbtr_pkg::rbtr_bus_type tgt_bus_in,
  input  wire logic [7:0]            probe_in,
  input  wire logic                  prog_run_in,
  output logic                       break_event_out,
  output logic                       trace_event_out
);
  import rbtr_pkg::*;

  localparam int unsigned PW       = $clog2(DEPTH);
  localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);
  localparam logic [PW:0] CNT_HALF = (PW + 1)'(DEPTH / 2);

  rbtr_bus_type   bus_m_q, bus_q;
  logic [7:0]     prb_m_q, prb_q;
  logic           run_m_q, run_q, run_p_q;
  logic [5:0]     us_div_q;
  logic [31:0]    ts_q;
  logic [11:0]    ctrl_q;
  logic [23:0]    tp_addr_q, start_addr_q, end_addr_q;
  logic [PW-1:0]  rd_idx_q, wr_ptr_q;
  logic           wrapped_q, trig_q, start_p_q, win_q;
  logic [PW:0]    remain_q;
  rbtr_state_type st_q;
  logic           wpend_q;
  logic [7:0]     addr_q;
  logic [1:0]     rd_pend_q;
  logic [31:0]    rd_mux;
  logic           ap_ok, arm_wr, halt, susp;
  logic           tp_hit, start_ev, end_ev, qual, pass, we;
  rbtr_range_type mode;
  rbtr_range_type arm_mode;
  rbtr_filt_type  filt;
  rbtr_qual_type  qmode;
  rbtr_entry_type ent;
  logic [ENTRY_W-1:0] ram_rdata;
  logic [127:0]   rd_vec;

  // Address match on a valid cycle, or the trace-trigger probe when selected.
  function automatic logic ev_hit(rbtr_bus_type b, logic [23:0] cmp, logic use_trg, logic trg);
    return use_trg ? trg : (!b.bus_cycle_valid_n && b.addr == cmp);
  endfunction

  // Two flops on every pin, plus a third on run for its edges; the first stage feeds no logic.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      bus_m_q <= '1;
      bus_q   <= '1;
      prb_m_q <= 8'h00;
      prb_q   <= 8'h00;
      run_m_q <= 1'b0;
      run_q   <= 1'b0;
      run_p_q <= 1'b0;
    end else if (clk_en_in) begin
      bus_m_q <= tgt_bus_in;
      bus_q   <= bus_m_q;
      prb_m_q <= probe_in;
      prb_q   <= prb_m_q;
      run_m_q <= prog_run_in;
      run_q   <= run_m_q;
      run_p_q <= run_q;
    end
  end

  assign halt = run_p_q & ~run_q;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      us_div_q <= 6'h00;
      ts_q     <= 32'h0000_0000;
    end else if (clk_en_in) begin
      if (run_q && !run_p_q) begin
        us_div_q <= 6'h00;
        ts_q     <= 32'h0000_0000;
      end else if (run_q) begin
        if (us_div_q == US_DIV_LAST) begin
          us_div_q <= 6'h00;
          ts_q     <= ts_q + 32'h0000_0001;
        end else begin
          us_div_q <= us_div_q + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      break_event_out <= 1'b0;
      trace_event_out <= 1'b0;
    end else if (clk_en_in) begin
      break_event_out <= prb_q[PRB_BREAK_BIT];
      trace_event_out <= prb_q[PRB_TRACE_BIT];
    end
  end

  assign mode  = rbtr_range_type'(ctrl_q[CTRL_MODE_LSB +: 3]);
  assign filt  = rbtr_filt_type'(ctrl_q[CTRL_FILT_LSB +: 2]);
  assign qmode = rbtr_qual_type'(ctrl_q[CTRL_QUAL_LSB +: 2]);
  assign susp  = ctrl_q[CTRL_SUSPEND];

  // events only on valid cycles or the trace probe
  assign tp_hit   = ev_hit(bus_q, tp_addr_q, ctrl_q[CTRL_TP_TRG], prb_q[PRB_TRACE_BIT]);
  assign start_ev = ev_hit(bus_q, start_addr_q, ctrl_q[CTRL_START_TRG], prb_q[PRB_TRACE_BIT]);
  assign end_ev   = ev_hit(bus_q, end_addr_q, ctrl_q[CTRL_END_TRG], prb_q[PRB_TRACE_BIT]);

  // window opens on start, closes after end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      start_p_q <= 1'b0;
      win_q     <= 1'b0;
    end else if (clk_en_in) begin
      start_p_q <= start_ev;
      // A fresh arm drops a window left open by the previous run.
      if (arm_wr) begin
        win_q <= 1'b0;
      end else if (start_ev) begin
        win_q <= 1'b1;
      end else if (end_ev) begin
        win_q <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (qmode)
      QUAL_SINGLE: qual = start_ev & ~start_p_q;
      QUAL_LEVEL:  qual = start_ev;
      default:     qual = start_ev | win_q;
    endcase
  end

  always_comb begin
    unique case (filt)
      FILT_SELECT:  pass = qual;
      FILT_EXCLUDE: pass = ~qual;
      default:      pass = 1'b1;
    endcase
  end

  always_comb begin
    unique case (st_q)
      // trigger cycle itself is not history
      ST_PRE:  we = pass & ~susp & ~(mode == RANGE_BEFORE && tp_hit);
      ST_POST: we = pass & ~susp;
      ST_WAIT: we = pass & ~susp & tp_hit;
      default: we = 1'b0;
    endcase
    we = we & clk_en_in;
  end

  always_comb begin
    ent              = '0;
    ent.bus          = bus_q;
    ent.bus_width_16 = BUS_WIDTH_16;
    ent.probes       = prb_q;
    ent.timestamp    = ts_q;
    if (bus_q.queue_fill > QFILL_MAX) begin
      ent.bus.queue_fill = QFILL_MAX;
    end
    if (bus_q.bus_cycle_valid_n) begin
      ent.bus.addr = 24'h00_0000;
      ent.bus.data = 16'h0000;
      ent.bus.bus_interface_unit  = BIU_NO_CHANGE;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      wr_ptr_q  <= '0;
      wrapped_q <= 1'b0;
    end else if (clk_en_in) begin
      if (arm_wr) begin
        wr_ptr_q  <= '0;
        wrapped_q <= 1'b0;
      end else if (we) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
        if (&wr_ptr_q) begin
          wrapped_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      st_q     <= ST_IDLE;
      remain_q <= '0;
      trig_q   <= 1'b0;
    end else if (clk_en_in) begin
      if (arm_wr) begin
        trig_q   <= 1'b0;
        remain_q <= CNT_FULL;
        unique case (arm_mode)
          RANGE_AFTER: st_q <= ST_WAIT;
          RANGE_FULL:  st_q <= ST_POST;
          default:     st_q <= ST_PRE;
        endcase
      end else begin
        unique case (st_q)
          ST_PRE: begin
            if (tp_hit && mode == RANGE_BEFORE) begin
              st_q   <= ST_DONE;
              trig_q <= 1'b1;
            end else if (tp_hit && mode == RANGE_ABOUT) begin
              st_q     <= ST_POST;
              remain_q <= CNT_HALF;
              trig_q   <= 1'b1;
            end else if (halt && mode != RANGE_BEFORE && mode != RANGE_ABOUT) begin
              st_q <= ST_DONE;
            end
          end
          ST_WAIT: begin
            if (tp_hit) begin
              st_q     <= ST_POST;
              remain_q <= CNT_FULL - {{PW{1'b0}}, we};
              trig_q   <= 1'b1;
            end
          end
          ST_POST: begin
            if (we) begin
              remain_q <= remain_q - 1'b1;
              if (remain_q == {{PW{1'b0}}, 1'b1}) begin
                st_q <= ST_DONE;
              end
            end
          end
          default: st_q <= st_q;
        endcase
      end
    end
  end

  rbtr_trace_ram #(
    .DEPTH (DEPTH),
    .WIDTH (ENTRY_W),
    .AW    (PW)
  ) u_ram (
    .clk_sys_in (clk_sys_in),
    .clk_en_in  (clk_en_in),
    .we_in      (we),
    .waddr_in   (wr_ptr_q),
    .wdata_in   (ent),
    .raddr_in   (rd_idx_q),
    .rdata_out  (ram_rdata)
  );

  // AHB-Lite slave: zero-wait writes, reads with two wait states for the memory.
  assign ap_ok  = hsel_in & htrans_in[1] & hready_in;
  assign arm_wr = wpend_q & (addr_q == OFS_CTRL) & hwdata_in[CTRL_ARM];
  // The range written together with the arm bit picks the start state, not the old one.
  assign arm_mode = rbtr_range_type'(hwdata_in[CTRL_MODE_LSB +: 3]);
  assign hreadyout_out = (rd_pend_q == 2'd0);
  assign hresp_out     = 1'b0;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      wpend_q    <= 1'b0;
      addr_q     <= 8'h00;
      rd_pend_q  <= 2'd0;
      hrdata_out <= 32'h0000_0000;
    end else if (clk_en_in) begin
      wpend_q <= ap_ok & hwrite_in;
      if (ap_ok) begin
        addr_q <= haddr_in[7:0];
      end
      if (ap_ok && !hwrite_in) begin
        rd_pend_q <= 2'd2;
      end else if (rd_pend_q != 2'd0) begin
        rd_pend_q <= rd_pend_q - 2'd1;
      end
      if (rd_pend_q == 2'd1) begin
        hrdata_out <= rd_mux;
      end
    end
  end

  // suspend and resume by writing the control word
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      ctrl_q       <= CTRL_RST;
      tp_addr_q    <= 24'h00_0000;
      start_addr_q <= 24'h00_0000;
      end_addr_q   <= 24'h00_0000;
      rd_idx_q     <= '0;
    end else if (clk_en_in && wpend_q) begin
      unique case (addr_q)
        OFS_CTRL:      ctrl_q <= hwdata_in[11:0] & CTRL_WR_MASK;
        OFS_TP_ADDR:   tp_addr_q <= hwdata_in[23:0];
        OFS_START_ADR: start_addr_q <= hwdata_in[23:0];
        OFS_END_ADR:   end_addr_q <= hwdata_in[23:0];
        OFS_RD_INDEX:  rd_idx_q <= hwdata_in[PW-1:0];
        default:       ctrl_q <= ctrl_q;
      endcase
    end
  end

  assign rd_vec = {{(128 - ENTRY_W){1'b0}}, ram_rdata};

  always_comb begin
    unique case (addr_q)
      OFS_CTRL:      rd_mux = {20'h0_0000, ctrl_q};
      OFS_STATUS:    rd_mux = {26'h000_0000, wrapped_q, trig_q, susp, st_q};
      OFS_WRPTR:     rd_mux = 32'(wr_ptr_q);
      OFS_TP_ADDR:   rd_mux = {8'h00, tp_addr_q};
      OFS_START_ADR: rd_mux = {8'h00, start_addr_q};
      OFS_END_ADR:   rd_mux = {8'h00, end_addr_q};
      OFS_RD_INDEX:  rd_mux = 32'(rd_idx_q);
      OFS_RD_WORD0:  rd_mux = rd_vec[31:0];
      OFS_RD_WORD1:  rd_mux = rd_vec[63:32];
      OFS_RD_WORD2:  rd_mux = rd_vec[95:64];
      OFS_RD_WORD3:  rd_mux = rd_vec[127:96];
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  property p_break_freeze;
    (clk_en_in && st_q == ST_PRE && mode == RANGE_BREAK && halt && !arm_wr)
      |=> st_q == ST_DONE ##1 $stable(wr_ptr_q);
  endproperty
  a_break_freeze: assert property (p_break_freeze) else $error("stop range did not freeze on halt");

  property p_before_stop;
    (clk_en_in && st_q == ST_PRE && mode == RANGE_BEFORE && tp_hit && !arm_wr) |-> !we ##1 st_q == ST_DONE;
  endproperty
  a_before_stop: assert property (p_before_stop) else $error("before range kept trigger or ran on");

  property p_about_half;
    (clk_en_in && st_q == ST_PRE && mode == RANGE_ABOUT && tp_hit && !arm_wr)
      |=> st_q == ST_POST && remain_q == CNT_HALF;
  endproperty
  a_about_half: assert property (p_about_half) else $error("about range half count wrong");

  property p_after_wait;
    (st_q == ST_WAIT && !tp_hit) |-> !we;
  endproperty
  a_after_wait: assert property (p_after_wait) else $error("after range wrote before match");

  property p_full_arm;
    (clk_en_in && arm_wr && arm_mode == RANGE_FULL) |=> st_q == ST_POST && remain_q == CNT_FULL && wr_ptr_q == '0;
  endproperty
  a_full_arm: assert property (p_full_arm) else $error("full range did not start counting");

  property p_total_all;
    (clk_en_in && st_q == ST_POST && !susp && filt == FILT_TOTAL) |-> we;
  endproperty
  a_total_all: assert property (p_total_all) else $error("total filter dropped a cycle");

  property p_exclude;
    (filt == FILT_EXCLUDE && qual) |-> !we;
  endproperty
  a_exclude: assert property (p_exclude) else $error("exclude filter stored a qualifying cycle");

  property p_single;
    (qmode == QUAL_SINGLE && qual) |-> start_ev && !start_p_q;
  endproperty
  a_single: assert property (p_single) else $error("single qualification longer than one cycle");

  property p_suspend;
    susp |-> !we;
  endproperty
  a_suspend: assert property (p_suspend) else $error("write while suspended");

  property p_entry_bhe;
    we |-> ent.bus.upper_byte_enable_n == bus_q.upper_byte_enable_n && ent.bus_width_16;
  endproperty
  a_entry_bhe: assert property (p_entry_bhe) else $error("entry lost byte enable or width");
endmodule
`default_nettype wire

//--- design/rbtr_trace_ram.sv
/*
  Trace memory: one write port and one registered read port.
  Assumes the caller gates writes with its clock enable.
*/
`default_nettype none
module rbtr_trace_ram #(
  parameter int unsigned DEPTH = 262144,
  parameter int unsigned WIDTH = 99,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             clk_sys_in,
  input  wire logic             clk_en_in,
  input  wire logic             we_in,
  input  wire logic [AW-1:0]    waddr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  input  wire logic [AW-1:0]    raddr_in,
  output logic      [WIDTH-1:0] rdata_out
);
  logic [WIDTH-1:0] mem [DEPTH];

  // No reset on the array so that it maps onto block memory.
  always_ff @(posedge clk_sys_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
    if (clk_en_in) begin
      rdata_out <= mem[raddr_in];
    end
  end
endmodule
`default_nettype wire

//--- sim/rbtr_recorder_tb.sv
/*
  Self-checking bench of the trace recorder, driven over AHB-Lite.
  Assumes a 16-entry trace memory so that full buffers are reached quickly.
*/
`default_nettype none
module rbtr_recorder_tb;
  import rbtr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic run = 1'b0;
  logic brk = 1'b0;
  logic trc = 1'b0;
  logic hready, rdy_s, brk_ev, trc_ev;
  logic [31:0] hrdata, rd_s, v, w;
  logic [7:0] probe;
  rbtr_bus_type tbus;
  rbtr_entry_type e0, e1;
  int n_fail = 0;
  int comparisons = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  // The ready and data seen at a rising edge are those settled before it.
  always @(negedge clk_sys_in) begin
    rdy_s <= hready;
    rd_s <= hrdata;
  end
  rbtr_tgt_model i_rbtr_tgt_model (.clk_sys_in(clk_sys_in), .run_in(run), .brk_in(brk), .trc_in(trc),
    .bus_out(tbus), .probe_out(probe));
  rbtr_recorder #(.DEPTH(16)) i_rbtr_recorder (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .clk_en_in(1'b1), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
    .hreadyout_out(hready), .hresp_out(), .tgt_bus_in(tbus), .probe_in(probe),
    .prog_run_in(run), .break_event_out(brk_ev), .trace_event_out(trc_ev));
  task automatic test_done();
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk_sys_in);
      k++;
    end while (rdy_s !== 1'b1 && k < 64);
    if (rdy_s !== 1'b1) n_fail++;
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = rd_s;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask
  task automatic arm(input logic [31:0] c);
    wr(OFS_CTRL, c | 32'h100);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic st_chk(input logic [2:0] x);
    rd(OFS_STATUS, v);
    chk("state", x, v[2:0]);
  endtask
  task automatic wp_chk(input logic [31:0] x);
    rd(OFS_WRPTR, v);
    chk("wrptr", x, v);
  endtask
  task automatic get(input logic [31:0] i, output rbtr_entry_type e);
    logic [127:0] q;
    wr(OFS_RD_INDEX, i);
    rd(OFS_RD_WORD0, q[31:0]);
    rd(OFS_RD_WORD1, q[63:32]);
    rd(OFS_RD_WORD2, q[95:64]);
    rd(OFS_RD_WORD3, q[127:96]);
    e = rbtr_entry_type'(q[ENTRY_W-1:0]);
  endtask
  task automatic chk_ent(input rbtr_entry_type e);
    logic [23:0] a;
    a = e.bus.addr;
    chk("valid_n", 32'h0, e.bus.bus_cycle_valid_n);
    chk("data", {a[7:0], ~a[7:0]}, e.bus.data);
    chk("ube_n", a[0], e.bus.upper_byte_enable_n);
    chk("qfill", a[3] ? 32'h8 : a[2:0], e.bus.queue_fill);
    chk("width", 32'h1, e.bus_width_16);
    chk("biu", a[2:0], e.bus.bus_interface_unit);
    chk("probes", {e.probes[7:6], 6'h2d}, e.probes);
  endtask
  initial begin
    idle(20000);
    n_fail++;
    test_done();
  end
  initial begin
    idle(2);
    rst_b_in <= 1'b1;
    rd(OFS_CTRL, v);
    chk("ctrl", 32'h0, v);
    st_chk(3'h0);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, v);
    chk("unmapped", 32'h0, v);
    wr(OFS_TP_ADDR, 32'h00123456);
    rd(OFS_TP_ADDR, v);
    chk("tp_addr", 32'h00123456, v);
    run <= 1'b1;
    arm(32'h4);
    idle(40);
    st_chk(3'h4);
    wp_chk(32'h0);
    get(0, e0);
    get(1, e1);
    chk_ent(e0);
    chk("next", e0.bus.addr + 24'h1, e1.bus.addr);
    arm(32'h403);
    idle(10);
    st_chk(3'h2);
    chk("trace_ev", 32'h0, trc_ev);
    trc <= 1'b1;
    brk <= 1'b1;
    idle(6);
    chk("trace_ev", 32'h1, trc_ev);
    chk("break_ev", 32'h1, brk_ev);
    idle(30);
    st_chk(3'h4);
    wp_chk(32'h0);
    get(0, e0);
    chk("match", 32'h1, e0.probes[PRB_TRACE_BIT]);
    chk_ent(e0);
    trc <= 1'b0;
    idle(6);
    arm(32'hac);
    idle(10);
    trc <= 1'b1;
    idle(3);
    trc <= 1'b0;
    idle(10);
    wp_chk(32'h3);
    arm(32'h8c);
    trc <= 1'b1;
    idle(3);
    trc <= 1'b0;
    idle(10);
    wp_chk(32'h1);
    trc <= 1'b1;
    idle(6);
    arm(32'hb4);
    idle(10);
    wp_chk(32'h0);
    trc <= 1'b0;
    idle(30);
    st_chk(3'h4);
    arm(32'hcc);
    idle(10);
    wp_chk(32'h0);
    trc <= 1'b1;
    idle(3);
    trc <= 1'b0;
    idle(30);
    st_chk(3'h4);
    arm(32'h401);
    idle(30);
    trc <= 1'b1;
    idle(10);
    trc <= 1'b0;
    st_chk(3'h4);
    chk("trig", 32'h1, v[4]);
    chk("wrapped", 32'h1, v[5]);
    rd(OFS_WRPTR, w);
    get(w - 32'h1, e0);
    chk("before_last", 32'h0, e0.probes[PRB_TRACE_BIT]);
    chk("stamp", 32'h1, e0.timestamp != 32'h0);
    arm(32'h402);
    idle(30);
    trc <= 1'b1;
    idle(20);
    trc <= 1'b0;
    st_chk(3'h4);
    rd(OFS_WRPTR, w);
    get(w - 32'h9, e0);
    get(w - 32'ha, e1);
    chk("about_trig", 32'h1, e0.probes[PRB_TRACE_BIT]);
    chk("about_pre", 32'h0, e1.probes[PRB_TRACE_BIT]);
    arm(32'h0);
    idle(5);
    wr(OFS_CTRL, 32'h200);
    rd(OFS_STATUS, v);
    chk("suspended", 32'h1, v[3]);
    rd(OFS_WRPTR, w);
    idle(20);
    wp_chk(w);
    wr(OFS_CTRL, 32'h0);
    idle(3);
    rd(OFS_WRPTR, v);
    chk("resumed", 32'h1, v != w);
    run <= 1'b0;
    idle(10);
    rd(OFS_WRPTR, w);
    idle(20);
    wp_chk(w);
    test_done();
  end
endmodule
`default_nettype wire

//--- sim/rbtr_tgt_model.sv
/*
  Target processor bus and probe cable model for the recorder bench.
  Assumes the recorder's clock; the bench steers the two trigger probes.
*/
`default_nettype none
module rbtr_tgt_model
  import rbtr_pkg::*;
(
  input  wire logic                 clk_sys_in,
  input  wire logic                 run_in,
  input  wire logic                 brk_in,
  input  wire logic                 trc_in,
  output var rbtr_pkg::rbtr_bus_type bus_out,
  output logic [7:0]                probe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] cnt_q = 24'h000000;
  always @(posedge clk_sys_in) begin
    if (run_in) cnt_q <= cnt_q + 24'h000001;
  end
  // valid strobe low.
  // Outside cycles the address carries its inverse and the data 5a5a, so a stale value never passes.
  always_comb begin
    bus_out = '0;
    bus_out.bus_cycle_valid_n = !run_in;
    bus_out.addr = run_in ? cnt_q : ~cnt_q;
    bus_out.data = run_in ? {cnt_q[7:0], ~cnt_q[7:0]} : 16'h5a5a;
    bus_out.upper_byte_enable_n = cnt_q[0];
    bus_out.bus_interface_unit = rbtr_biu_type'({1'b0, cnt_q[2:0]});
    bus_out.rw = 2'h1;
    bus_out.queue_fill = cnt_q[3] ? 4'h8 : {1'b0, cnt_q[2:0]};
    probe_out = {brk_in, trc_in, 6'h2d};
  end
endmodule
`default_nettype wire
